// ---- core/seerd_pkg.sv ----
// Shared constants and types for the serial EEPROM read and acknowledge-poll ends.
package seerd_pkg;
	localparam int ADDR_W      = 13;                 // Width of the internal byte address counter.
	localparam int MEM_DEPTH   = 8192;               // Bytes held by the array.
	localparam int BYTE_W      = 8;                  // Width of one data byte.
	localparam logic [7:0] ERASED_BYTE = 8'hFF;      // Content of every location on delivery.
	localparam logic [6:0] SEL_CODE    = 7'h50;      // Upper seven bits of the device select byte.
	localparam int HI_BITS     = 5;                  // Address bits carried by the first address byte.
	localparam int PAGE_BITS   = 5;                  // Low address bits that wrap inside a write page.
	localparam int CLK_MHZ     = 100;                // System clock rate.
	localparam int T_PROG_MS   = 10;                 // Longest self-timed program cycle.
	localparam int PROG_CYCLES = T_PROG_MS * 1000 * CLK_MHZ; // Program cycle in clock cycles.
	localparam int PROG_CNT_W  = 20;                 // Width of the program cycle counter.
	localparam int QDIV        = 8;                  // Clock cycles per quarter of a link bit.
	localparam int FIFO_DEPTH  = 8;                  // Words in the read data FIFO.
	localparam int LEN_W       = 8;                  // Width of a transfer length.

	// Transfer kinds that the host end accepts.
	localparam logic [1:0] OP_WRITE    = 2'h0;
	localparam logic [1:0] OP_CUR_READ = 2'h1;
	localparam logic [1:0] OP_RND_READ = 2'h2;

	// Device end bit-level states.
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX   = 5'h02,
		D_RACK = 5'h04,
		D_TX   = 5'h08,
		D_TACK = 5'h10
	} seerd_dst_t;

	// Which byte of an instruction the device is collecting.
	typedef enum logic [3:0] {
		G_SEL = 4'h1,
		G_AHI = 4'h2,
		G_ALO = 4'h4,
		G_DAT = 4'h8
	} seerd_stage_t;

	// Host end bus states.
	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_TX    = 5'h04,
		H_RX    = 5'h08,
		H_STOP  = 5'h10
	} seerd_hst_t;

	// Which byte of a transfer the host is sending or receiving.
	typedef enum logic [5:0] {
		S_SELW = 6'h01,
		S_AHI  = 6'h02,
		S_ALO  = 6'h04,
		S_WDAT = 6'h08,
		S_SELR = 6'h10,
		S_RDAT = 6'h20
	} seerd_hseq_t;
endpackage

// ---- core/seerd_if.sv ----
// Two-wire link between the host end and the device end.
`timescale 1ns/1ps
interface seerd_if;
	logic scl;          // Serial clock, made by the host.
	logic host_sda_o;   // Host data value, always low.
	logic host_sda_oe;  // High while the host pulls data low.
	logic dev_sda_o;    // Device data value, always low.
	logic dev_sda_oe;   // High while the device pulls data low.
	logic sda;          // Resolved open-drain data line.

	// The line is pulled up and any enabled low driver wins.
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ---- core/seerd_device.sv ----
// Device end: two-wire EEPROM slave with reads, writes and a self-timed program cycle.
`timescale 1ns/1ps

module seerd_device #(
	parameter int PROG_CYC = seerd_pkg::PROG_CYCLES  // Program cycle length in clock cycles.
) (
	input  wire logic clk,        // System clock.
	input  wire logic rst_n,      // Synchronous reset, active low.
	seerd_if.dev      link,       // Two-wire link to the host.
	output logic      prog_busy   // High while the program cycle runs.
);
	import seerd_pkg::*;

	// Byte array; the read port is combinational so a byte is ready on the falling edge.
	logic [BYTE_W-1:0]     mem [MEM_DEPTH];

	// Two-flop synchronisers followed by one history stage for edge finding.
	logic                  scl_m_r;     // First synchroniser stage of the clock.
	logic                  scl_s_r;     // Second synchroniser stage of the clock.
	logic                  scl_d_r;     // Delayed clock for edge detection.
	logic                  sda_m_r;     // First synchroniser stage of data.
	logic                  sda_s_r;     // Second synchroniser stage of data.
	logic                  sda_d_r;     // Delayed data for condition detection.

	seerd_dst_t            st_r;        // Bit-level state.
	seerd_dst_t            st_nxt;
	seerd_stage_t          stage_r;     // Byte role inside the instruction.
	seerd_stage_t          stage_nxt;
	logic [3:0]            bit_r;       // Bits moved in the current byte.
	logic [3:0]            bit_nxt;
	logic [BYTE_W-1:0]     sh_r;        // Receive or transmit shift register.
	logic [BYTE_W-1:0]     sh_nxt;
	logic [ADDR_W-1:0]     addr_r;      // Internal address counter.
	logic [ADDR_W-1:0]     addr_nxt;
	logic                  rw_r;        // Read bit of the last select byte received, matched or not.
	logic                  rw_nxt;
	logic                  wr_seen_r;   // A data byte was written since the start.
	logic                  wr_seen_nxt;
	logic                  post_ack_r;  // Inside the slot that follows an acknowledge.
	logic                  post_ack_nxt;
	logic                  oe_r;        // Data line pull-down enable.
	logic                  oe_nxt;
	logic                  busy_r;      // Program cycle running.
	logic                  busy_nxt;
	logic [PROG_CNT_W-1:0] cnt_r;       // Cycles left in the program cycle.
	logic [PROG_CNT_W-1:0] cnt_nxt;
	logic                  mem_we;      // Write strobe for the array.

	// Decoded link events, all taken from the second stage onward.
	wire                   scl_rise  = scl_s_r & ~scl_d_r;
	wire                   scl_fall  = ~scl_s_r & scl_d_r;
	wire                   start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire                   stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
	wire [BYTE_W-1:0]      mem_rd    = mem[addr_r];
	wire                   sel_hit   = (sh_r[7:1] == SEL_CODE);
	wire [PAGE_BITS-1:0]   page_inc  = addr_r[PAGE_BITS-1:0] + 5'h1;

	// The array carries no reset, so it is filled once at power-up.
	initial begin
		for (int i = 0; i < MEM_DEPTH; i++) begin
			mem[i] = ERASED_BYTE;
		end
	end

	// Array write port, used by the data bytes of a write.
	// A plain clocked process, since the power-up fill above also writes the array.
	always @(posedge clk) begin
		if (mem_we) begin
			mem[addr_r] <= sh_r;
		end
	end

	// Synchronisers; the idle bus level is high on both lines.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end else begin
			{scl_m_r, scl_s_r, scl_d_r} <= {link.scl, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {link.sda, sda_m_r, sda_s_r};
		end
	end

	// Next-state logic for the whole slave; one event is handled per cycle.
	always_comb begin
		st_nxt       = st_r;
		stage_nxt    = stage_r;
		bit_nxt      = bit_r;
		sh_nxt       = sh_r;
		addr_nxt     = addr_r;
		rw_nxt       = rw_r;
		wr_seen_nxt  = wr_seen_r;
		post_ack_nxt = post_ack_r;
		oe_nxt       = oe_r;
		busy_nxt     = busy_r;
		cnt_nxt      = cnt_r;
		mem_we       = 1'b0;
		if (busy_r) begin
			// Deaf to the bus, so a polling select gets no acknowledge.
			st_nxt = D_IDLE;
			oe_nxt = 1'b0;
			if (cnt_r == '0) begin
				busy_nxt = 1'b0;
			end else begin
				cnt_nxt = cnt_r - 20'h0_0001;
			end
		end else if (start_det) begin
			// Outside a program cycle, a start or repeated start always opens a new instruction.
			st_nxt       = D_RX;
			stage_nxt    = G_SEL;
			bit_nxt      = 4'h0;
			oe_nxt       = 1'b0;
			post_ack_nxt = 1'b0;
			wr_seen_nxt  = 1'b0;
		end else if (stop_det) begin
			// Only a stop in the slot after an acknowledge of written data programs.
			if (post_ack_r && wr_seen_r) begin
				busy_nxt = 1'b1;
				cnt_nxt  = PROG_CNT_W'(PROG_CYC - 1);
			end
			st_nxt       = D_IDLE;
			oe_nxt       = 1'b0;
			post_ack_nxt = 1'b0;
		end else begin
			case (st_r)
				D_RX: begin
					if (scl_rise && bit_r != 4'h8) begin
						sh_nxt       = {sh_r[6:0], sda_s_r};
						bit_nxt      = bit_r + 4'h1;
					end else if (scl_fall && bit_r != 4'h8) begin
						// A stop lands while the clock is high, so the slot only closes on the fall.
						post_ack_nxt = 1'b0;
					end else if (scl_fall && bit_r == 4'h8) begin
						// A full byte is in; decide on the acknowledge.
						oe_nxt = 1'b1;
						st_nxt = D_RACK;
						case (stage_r)
							G_SEL: begin
								rw_nxt = sh_r[0];
								if (!sel_hit) begin
									oe_nxt = 1'b0;
									st_nxt = D_IDLE;
								end
							end
							G_AHI: begin
								addr_nxt = {sh_r[HI_BITS-1:0], addr_r[7:0]};
							end
							G_ALO: begin
								addr_nxt = {addr_r[ADDR_W-1:8], sh_r};
							end
							G_DAT: begin
								mem_we      = 1'b1;
								addr_nxt    = {addr_r[ADDR_W-1:PAGE_BITS], page_inc};
								wr_seen_nxt = 1'b1;
							end
							default: begin
								st_nxt = D_IDLE;
								oe_nxt = 1'b0;
							end
						endcase
					end
				end
				D_RACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							// Send the byte at the counter, then step the counter.
							sh_nxt   = mem_rd;
							addr_nxt = addr_r + 13'h1;
							oe_nxt   = ~mem_rd[7];
							bit_nxt  = 4'h0;
							st_nxt   = D_TX;
						end else begin
							oe_nxt       = 1'b0;
							bit_nxt      = 4'h0;
							post_ack_nxt = 1'b1;
							st_nxt       = D_RX;
							case (stage_r)
								G_SEL:   stage_nxt = G_AHI;
								G_AHI:   stage_nxt = G_ALO;
								default: stage_nxt = G_DAT;
							endcase
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (bit_r == 4'h7) begin
							oe_nxt  = 1'b0;
							bit_nxt = 4'h0;
							st_nxt  = D_TACK;
						end else begin
							bit_nxt = bit_r + 4'h1;
							sh_nxt  = {sh_r[6:0], 1'b0};
							oe_nxt  = ~sh_r[6];
						end
					end
				end
				D_TACK: begin
					if (scl_rise) begin
						// Ninth slot: a high line is a refusal and ends the read.
						if (sda_s_r) begin
							st_nxt = D_IDLE;
						end else begin
							bit_nxt = 4'h8;
						end
					end else if (scl_fall && bit_r == 4'h8) begin
						sh_nxt   = mem_rd;
						addr_nxt = addr_r + 13'h1;
						oe_nxt   = ~mem_rd[7];
						bit_nxt  = 4'h0;
						st_nxt   = D_TX;
					end
				end
				default: begin
					st_nxt = D_IDLE;
				end
			endcase
		end
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r       <= D_IDLE;
			stage_r    <= G_SEL;
			bit_r      <= 4'h0;
			sh_r       <= 8'h00;
			addr_r     <= 13'h0;
			rw_r       <= 1'b0;
			wr_seen_r  <= 1'b0;
			post_ack_r <= 1'b0;
			oe_r       <= 1'b0;
			busy_r     <= 1'b0;
			cnt_r      <= 20'h0_0000;
		end else begin
			st_r       <= st_nxt;
			stage_r    <= stage_nxt;
			bit_r      <= bit_nxt;
			sh_r       <= sh_nxt;
			addr_r     <= addr_nxt;
			rw_r       <= rw_nxt;
			wr_seen_r  <= wr_seen_nxt;
			post_ack_r <= post_ack_nxt;
			oe_r       <= oe_nxt;
			busy_r     <= busy_nxt;
			cnt_r      <= cnt_nxt;
		end
	end

	// The pin only ever pulls low, so its value is a constant.
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = oe_r;
	assign prog_busy       = busy_r;
endmodule // seerd_device

// ---- core/seerd_host.sv ----
// Host end: two-wire bus master with ack polling and a read data FIFO.
`timescale 1ns/1ps

// Small synchronous FIFO; full and empty follow the word count.
module seerd_fifo #(
	parameter int W = 8,  // Word width.
	parameter int D = 8   // Depth in words, a power of two.
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0]         buf_r [D];  // Storage.
	logic [$clog2(D)-1:0] wp_r;       // Write pointer.
	logic [$clog2(D)-1:0] rp_r;       // Read pointer.
	logic [$clog2(D):0]   cnt_r;      // Words held.
	wire                  push = in_valid & in_ready;
	wire                  pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != ($clog2(D)+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = buf_r[rp_r];

	// Storage has no reset; only the pointers and the count need one.
	always_ff @(posedge clk) begin
		if (push) begin
			buf_r[wp_r] <= in_data;
		end
	end

	// Pointers and count.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_r + {{($clog2(D)-1){1'b0}}, push};
			rp_r  <= rp_r + {{($clog2(D)-1){1'b0}}, pop};
			cnt_r <= cnt_r + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
		end
	end
endmodule // seerd_fifo

module seerd_host #(
	parameter int QD = seerd_pkg::QDIV  // Clock cycles per quarter bit.
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	seerd_if.host                         link,
	input  wire logic                     cmd_valid,
	output logic                          cmd_ready,
	input  wire logic [1:0]               cmd_op,
	input  wire logic [seerd_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [seerd_pkg::LEN_W-1:0]  cmd_len,
	input  wire logic [seerd_pkg::BYTE_W-1:0] wr_data,
	output logic                          wr_take,
	output logic                          rd_valid,
	input  wire logic                     rd_ready,
	output logic [seerd_pkg::BYTE_W-1:0]  rd_data,
	output logic                          done,
	output logic                          nack_err
);
	import seerd_pkg::*;

	logic              sda_m_r;    // First synchroniser stage of data.
	logic              sda_s_r;    // Second synchroniser stage of data.
	seerd_hst_t        hs_r;       // Bus state.
	seerd_hst_t        hs_nxt;
	seerd_hseq_t       sq_r;       // Byte role.
	seerd_hseq_t       sq_nxt;
	logic [7:0]        div_r;      // Quarter divider.
	logic [1:0]        q_r;        // Quarter inside the bit.
	logic [1:0]        q_nxt;
	logic [3:0]        bit_r;      // Bit inside the byte.
	logic [3:0]        bit_nxt;
	logic [7:0]        sh_r;       // Shift register.
	logic [7:0]        sh_nxt;
	logic [1:0]        op_r;       // Latched kind of transfer.
	logic [ADDR_W-1:0] addr_r;     // Latched start address.
	logic [LEN_W-1:0]  len_r;      // Bytes still to move.
	logic [LEN_W-1:0]  len_nxt;
	logic              ack_r;      // Acknowledge seen in the last ninth slot.
	logic              ack_nxt;
	logic              scl_r;
	logic              scl_nxt;
	logic              oe_r;
	logic              oe_nxt;
	logic              push;       // Hand a received byte to the FIFO.
	logic              take_nxt;
	logic              done_nxt;
	logic              err_nxt;
	logic              fifo_rdy;   // FIFO has room.
	wire               tick  = (div_r == 8'(QD - 1));
	wire               stall = (hs_r == H_RX) && (bit_r == 4'h0) && (q_r == 2'h0) && !fifo_rdy;

	// Received bytes wait here; a full FIFO holds the clock low.
	seerd_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   ({sh_r[6:0], sda_s_r}),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// Bus sequencing; every action after the command is taken from idle lands on a quarter tick.
	always_comb begin
		hs_nxt = hs_r; sq_nxt = sq_r; q_nxt = q_r; bit_nxt = bit_r; sh_nxt = sh_r;
		len_nxt = len_r; ack_nxt = ack_r; scl_nxt = scl_r; oe_nxt = oe_r;
		push = 1'b0; take_nxt = 1'b0; done_nxt = 1'b0; err_nxt = 1'b0;
		if (hs_r == H_IDLE) begin
			if (cmd_valid) begin
				hs_nxt  = H_START;
				sq_nxt  = (cmd_op == OP_CUR_READ) ? S_SELR : S_SELW;
				q_nxt   = 2'h0;
				len_nxt = cmd_len;
			end
		end else if (tick && !stall) begin
			q_nxt = q_r + 2'h1;
			case (hs_r)
				H_START: begin
					// Release, raise the clock, pull data low, drop the clock.
					case (q_r)
						2'h0: begin scl_nxt = 1'b0; oe_nxt = 1'b0; end
						2'h1: scl_nxt = 1'b1;
						2'h2: oe_nxt = 1'b1;
						default: begin
							scl_nxt = 1'b0; hs_nxt = H_TX; bit_nxt = 4'h0;
							sh_nxt  = {SEL_CODE, (sq_r == S_SELR)};
						end
					endcase
				end
				H_TX: begin
					case (q_r)
						2'h0: oe_nxt = (bit_r != 4'h8) && !sh_r[7];
						2'h1: scl_nxt = 1'b1;
						2'h2: if (bit_r == 4'h8) ack_nxt = !sda_s_r;
						default: begin
							scl_nxt = 1'b0;
							bit_nxt = bit_r + 4'h1;
							sh_nxt  = {sh_r[6:0], 1'b0};
							if (bit_r == 4'h8) begin
								bit_nxt = 4'h0;
								if (!ack_r && (sq_r == S_SELW || sq_r == S_SELR)) begin
									hs_nxt = H_START;
								end else if (!ack_r) begin
									err_nxt = 1'b1; hs_nxt = H_STOP;
								end else begin
									case (sq_r)
										S_SELW: begin sq_nxt = S_AHI; sh_nxt = {3'h0, addr_r[12:8]}; end
										S_AHI: begin sq_nxt = S_ALO; sh_nxt = addr_r[7:0]; end
										S_ALO: begin
											if (op_r == OP_WRITE) begin
												sq_nxt = S_WDAT; sh_nxt = wr_data; take_nxt = 1'b1;
											end else begin
												sq_nxt = S_SELR; hs_nxt = H_START;
											end
										end
										S_WDAT: begin
											len_nxt = len_r - 8'h01;
											if (len_r == 8'h01) hs_nxt = H_STOP;
											else begin sh_nxt = wr_data; take_nxt = 1'b1; end
										end
										default: begin sq_nxt = S_RDAT; hs_nxt = H_RX; end
									endcase
								end
							end
						end
					endcase
				end
				H_RX: begin
					case (q_r)
						2'h0: oe_nxt = (bit_r == 4'h8) && (len_r != 8'h01);
						2'h1: scl_nxt = 1'b1;
						2'h2: begin
							if (bit_r != 4'h8) sh_nxt = {sh_r[6:0], sda_s_r};
							push = (bit_r == 4'h7);
						end
						default: begin
							scl_nxt = 1'b0;
							bit_nxt = bit_r + 4'h1;
							if (bit_r == 4'h8) begin
								bit_nxt = 4'h0;
								len_nxt = len_r - 8'h01;
								if (len_r == 8'h01) hs_nxt = H_STOP;
							end
						end
					endcase
				end
				H_STOP: begin
					case (q_r)
						2'h0: begin scl_nxt = 1'b0; oe_nxt = 1'b1; end
						2'h1: scl_nxt = 1'b1;
						2'h2: oe_nxt = 1'b0;
						default: begin hs_nxt = H_IDLE; done_nxt = 1'b1; end
					endcase
				end
				default: hs_nxt = H_IDLE;
			endcase
		end
	end

	// Divider, synchroniser and command latch.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 8'h00; sda_m_r <= 1'b1; sda_s_r <= 1'b1;
			op_r <= OP_WRITE; addr_r <= 13'h0;
		end else begin
			div_r <= (tick || hs_r == H_IDLE) ? 8'h00 : div_r + 8'h01;
			{sda_m_r, sda_s_r} <= {link.sda, sda_m_r};
			if (hs_r == H_IDLE && cmd_valid) begin
				op_r <= cmd_op; addr_r <= cmd_addr;
			end
		end
	end

	// Sequencer registers and flopped outputs.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hs_r <= H_IDLE; sq_r <= S_SELW; q_r <= 2'h0; bit_r <= 4'h0; sh_r <= 8'h00;
			len_r <= 8'h00; ack_r <= 1'b0; scl_r <= 1'b1; oe_r <= 1'b0;
			wr_take <= 1'b0; done <= 1'b0; nack_err <= 1'b0; cmd_ready <= 1'b1;
		end else begin
			hs_r <= hs_nxt; sq_r <= sq_nxt; q_r <= q_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt;
			len_r <= len_nxt; ack_r <= ack_nxt; scl_r <= scl_nxt; oe_r <= oe_nxt;
			wr_take <= take_nxt; done <= done_nxt; nack_err <= err_nxt;
			cmd_ready <= (hs_nxt == H_IDLE);
		end
	end

	assign link.scl         = scl_r;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = oe_r;
endmodule // seerd_host

// ---- tb/seerd_props.sv ----
// Concurrent checks on the two-wire link between the host end and the device end.
`timescale 1ns/1ps
module seerd_props #(
	parameter int PROG_CYC = 600  // Program cycle length in clock cycles.
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda,
	input wire logic prog_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [19:0] busy_r;  // Cycles spent programming so far.
	// Count the program cycle, since its length is far past any repetition count.
	always_ff @(posedge clk) begin
		busy_r <= (!rst_n || !prog_busy) ? 20'h0_0000 : busy_r + 20'h0_0001;
	end
	a_busy_quiet: assert property (prog_busy |-> !dev_sda_oe)
		else $error("device drove data while programming");
	a_busy_on_stop: assert property ($rose(prog_busy) |-> scl && sda)
		else $error("program cycle began without a stop");
	a_busy_len: assert property ($fell(prog_busy) |-> busy_r >= PROG_CYC)
		else $error("program cycle ended early");
	a_busy_bound: assert property (busy_r <= PROG_CYC + 1)
		else $error("program cycle ran too long");
	a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	a_no_dev_cond: assert property ($changed(sda) && scl && $past(scl) |-> $changed(host_sda_oe))
		else $error("device made a start or stop");
	a_ack_hold: assert property ($rose(dev_sda_oe) |=> dev_sda_oe [*8])
		else $error("device low pulse too short");
	a_scl_high: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	// Main scenarios: programming seen, finished, and device driving.
	cover property ($rose(prog_busy));
	cover property ($fell(prog_busy));
	cover property ($rose(dev_sda_oe));
endmodule // seerd_props

// ---- tb/serial_eeprom_read_and_ack_poll_tb.sv ----
// Self-checking bench joining the host end and the device end over the link.
`timescale 1ns/1ps
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module serial_eeprom_read_and_ack_poll_tb;
	import seerd_pkg::*;
	localparam int PROG = 600;  // Short program cycle that still outlasts a select byte.
	logic              clk, rst_n, cmd_valid, cmd_ready, wr_take, rd_valid, rd_ready, done, nack_err, prog_busy;
	logic [1:0]        cmd_op;
	logic [ADDR_W-1:0] cmd_addr;
	logic [LEN_W-1:0]  cmd_len;
	logic [BYTE_W-1:0] wr_data, rd_data, rq[$], eq[$];
	logic              nack_seen, busy_seen;
	int                errors, n_tests, cyc;
	seerd_if link();
	seerd_device #(.PROG_CYC(PROG)) i_seerd_device (.clk(clk), .rst_n(rst_n), .link(link), .prog_busy(prog_busy));
	seerd_host #(.QD(QDIV)) i_seerd_host (.clk(clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
		.wr_take(wr_take), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .done(done), .nack_err(nack_err));
	seerd_props #(.PROG_CYC(PROG)) i_seerd_props (.clk(clk), .rst_n(rst_n), .scl(link.scl),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .prog_busy(prog_busy));
	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sample just after the falling edge, where every output has settled.
	always @(negedge clk) begin
		#1;
		cyc++;
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			rq.push_back(rd_data);
		end
		if (nack_err === 1'b1) nack_seen = 1'b1;
		if (prog_busy === 1'b1) busy_seen = 1'b1;
		// A hang counts as a mismatch and ends the run.
		if (cyc == 60000) begin
			errors++;
			stop_test();
		end
	end
	// Issue one transfer; a stall holds the read stream back for 6000 cycles so the buffer fills.
	task automatic do_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n,
			input logic [BYTE_W-1:0] d, input bit stall);
		int t;
		@(negedge clk);
		{cmd_op, cmd_addr, cmd_len, wr_data, cmd_valid, rd_ready} <= {op, a, n, d, 1'b1, !stall};
		@(negedge clk);
		cmd_valid <= 1'b0;
		`CHK(cmd_ready, 1'b0)
		if (stall) begin
			repeat (6000) @(negedge clk);
			rd_ready <= 1'b1;
		end
		// The next write byte is offered once the host has taken the current one.
		for (t = 0; t < 20000 && done !== 1'b1; t++) begin
			@(negedge clk);
			if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
		end
		`CHK(done, 1'b1)
		repeat (12) @(negedge clk);
	endtask
	// Compare the collected read bytes with the expected ones, then clear both.
	task automatic check_rd();
		`CHK(rq.size(), eq.size())
		foreach (eq[i]) `CHK(rq[i], eq[i])
		rq.delete();
		eq.delete();
	endtask
	// Print the verdict and end the run.
	task automatic stop_test();
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		{rst_n, cmd_valid, cmd_op, cmd_addr, cmd_len, wr_data, rd_ready} = '0;
		{nack_seen, busy_seen, errors, n_tests, cyc} = '0;
		rd_ready = 1'b1;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		do_cmd(OP_RND_READ, 13'h0100, 8'h03, 8'h00, 1'b0);
		eq = '{ERASED_BYTE, ERASED_BYTE, ERASED_BYTE};
		check_rd();
		do_cmd(OP_WRITE, 13'h0000, 8'h01, 8'h3C, 1'b0);
		do_cmd(OP_WRITE, 13'h1FFE, 8'h02, 8'hA5, 1'b0);
		do_cmd(OP_RND_READ, 13'h1FFE, 8'h02, 8'h00, 1'b0);
		eq = '{8'hA5, 8'hA6};
		check_rd();
		do_cmd(OP_CUR_READ, 13'h0000, 8'h01, 8'h00, 1'b0);
		eq = '{8'h3C};
		check_rd();
		do_cmd(OP_RND_READ, 13'h1FFF, 8'h0A, 8'h00, 1'b1);
		eq = '{8'hA6, 8'h3C, ERASED_BYTE, ERASED_BYTE, ERASED_BYTE, ERASED_BYTE, ERASED_BYTE, ERASED_BYTE,
			ERASED_BYTE, ERASED_BYTE};
		check_rd();
		`CHK(nack_seen, 1'b0)
		`CHK(busy_seen, 1'b1)
		stop_test();
	end
endmodule // serial_eeprom_read_and_ack_poll_tb
